// >>> framer_interrupt_and_status_map_bench.sv
/*
 * Self-checking bench for the framer interrupt and status map.
 * Assumes the design files and frm_defines.svh are compiled alongside.
 */
`timescale 1ns/1ps
`include "frm_defines.svh"
module framer_interrupt_and_status_map_bench;
  // ****************************************************************
  // Signals and design under test.
  // ****************************************************************
  typedef struct {
    logic w;
    logic [11:0] idx;
    logic [7:0] d;
    logic [3:0] s;
    logic [7:0] exp;
    logic err;
  } frm_row_t;
  logic clk;
  logic rst;
  logic [15:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [511:0] chan_event;
  logic [8*`FRM_MON_BYTES*8-1:0] chan_monitor;
  logic [7:0] link_event;
  logic irq_out;
  logic irq_oe;
  int mismatches;
  int checks_done;
  logic [31:0] r;
  logic e;
  logic [7:0] offs [8] = '{8'h08, 8'h09, 8'h14, 8'h33,
                           8'h34, 8'h3F, 8'h40, 8'h5F};
  // Reads, plain writes, a masked write, a read-only write, unmapped.
  frm_row_t rows [19] = '{
    '{1'b0, 12'h000, 8'h00, 4'hF, 8'h00, 1'b0},
    '{1'b0, 12'h001, 8'h00, 4'hF, 8'h00, 1'b0},
    '{1'b0, 12'h002, 8'h00, 4'hF, 8'h00, 1'b0},
    '{1'b0, 12'h003, 8'h00, 4'hF, 8'h00, 1'b0},
    '{1'b0, 12'h004, 8'h00, 4'hF, 8'h00, 1'b0},
    '{1'b0, 12'h005, 8'h5A, 4'hF, 8'h5A, 1'b0},
    '{1'b0, 12'h006, 8'h00, 4'hF, 8'hA5, 1'b0},
    '{1'b0, 12'h007, 8'h00, 4'hF, 8'h01, 1'b0},
    '{1'b0, 12'h008, 8'h00, 4'hF, 8'h00, 1'b0},
    '{1'b0, 12'h009, 8'h00, 4'hF, 8'h00, 1'b0},
    '{1'b1, 12'h008, 8'hC3, 4'hF, 8'h00, 1'b0},
    '{1'b1, 12'h008, 8'hFF, 4'hE, 8'h00, 1'b0},
    '{1'b0, 12'h008, 8'h00, 4'hF, 8'hC3, 1'b0},
    '{1'b1, 12'h009, 8'h3C, 4'hF, 8'h00, 1'b0},
    '{1'b0, 12'h009, 8'h00, 4'hF, 8'h3C, 1'b0},
    '{1'b1, 12'h005, 8'h00, 4'hF, 8'h00, 1'b0},
    '{1'b0, 12'h005, 8'h00, 4'hF, 8'h5A, 1'b0},
    '{1'b0, 12'h00A, 8'h00, 4'hF, 8'h00, 1'b1},
    '{1'b1, 12'h100, 8'h11, 4'hF, 8'h00, 1'b1}};

  frm_irq_top uut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_event(chan_event),
    .chan_monitor(chan_monitor), .link_event(link_event),
    .irq_out(irq_out), .irq_oe(irq_oe)
  );

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Monitor byte pattern; distinct per framer so a wrong digit shows.
  function automatic logic [7:0] mval(input int k);
    return 8'((k * 7 + 3) % 256);
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [7:0] d, input logic [3:0] s);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hF);
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 4'hF);
    check("rdata", r, {24'h000000, exp});
    check("pslverr", {31'h00000000, e}, 32'h00000000);
  endtask

  // Pulse one condition bit, then let status, summary and pin settle.
  task automatic ev(input int n, input logic link);
    if (link) begin
      link_event[n] <= 1'b1;
    end else begin
      chan_event[n] <= 1'b1;
    end
    @(posedge clk);
    chan_event <= '0;
    link_event <= '0;
    repeat (4) @(posedge clk);
  endtask

  // In a released state the level is meaningless, so only oe counts.
  task automatic pin(input logic o, input logic oe);
    check("irq_oe", {31'h00000000, irq_oe}, {31'h00000000, oe});
    if (oe) begin
      check("irq_out", {31'h00000000, irq_out}, {31'h00000000, o});
    end
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence.
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    paddr = 16'h0000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    chan_event = '0;
    link_event = 8'h00;
    for (int k = 0; k < 8 * `FRM_MON_BYTES; k++) begin
      chan_monitor[k*8 +: 8] = mval(k);
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pin(1'b0, 1'b1);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].d, rows[i].s);
      check("row err", {31'h00000000, e}, {31'h00000000, rows[i].err});
      if (!rows[i].w && !rows[i].err) begin
        check("row rdata", r, {24'h000000, rows[i].exp});
      end
    end
    // Monitor bytes of every framer, counter edges and arrays.
    for (int f = 0; f < 8; f++) begin
      foreach (offs[j]) begin
        rdchk({4'(f + 2), offs[j]}, mval(f * 88 + offs[j] - 8));
      end
    end
    // Each framer, a different status byte and bit each time.
    for (int f = 0; f < 8; f++) begin
      wr({4'(f + 2), 8'(8'h60 + f)}, 8'(1 << (7 - f)));
      wr(12'h001, 8'(1 << f));
      ev(f * 64 + f * 8 + 7 - f, 1'b0);
      pin(1'b1, 1'b1);
      rdchk(12'h000, 8'(1 << f));
      rdchk({4'(f + 2), 8'(f)}, 8'(1 << (7 - f)));
      repeat (4) @(posedge clk);
      pin(1'b0, 1'b1);
      rdchk({4'(f + 2), 8'(f)}, 8'h00);
      wr({4'(f + 2), 8'(8'h60 + f)}, 8'h00);
    end
    // Own enable off, then block enable off: no request either way.
    wr(12'h001, 8'h01);
    ev(0, 1'b0);
    pin(1'b0, 1'b1);
    rdchk(12'h200, 8'h01);
    wr(12'h260, 8'h01);
    wr(12'h001, 8'h00);
    ev(0, 1'b0);
    pin(1'b0, 1'b1);
    wr(12'h001, 8'h01);
    repeat (4) @(posedge clk);
    pin(1'b1, 1'b1);
    // Two sources pending; clearing one must keep the pin asserted.
    wr(12'hA02, 8'h08);
    wr(12'h003, 8'h01);
    ev(3, 1'b1);
    rdchk(12'h002, 8'h01);
    wr(12'hA00, 8'h08);
    repeat (4) @(posedge clk);
    pin(1'b1, 1'b1);
    rdchk(12'hA00, 8'h00);
    rdchk(12'h200, 8'h01);
    repeat (4) @(posedge clk);
    pin(1'b0, 1'b1);
    // All four pin modes, idle and asserted.
    wr(12'hA02, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(12'h004, {1'b0, 1'(m >> 1), 1'b0, 1'(m), 4'h0});
      rdchk(12'h004, {1'b0, 1'(m >> 1), 1'b0, 1'(m), 4'h0});
      repeat (4) @(posedge clk);
      pin(1'(m >> 1), !1'(m));
      ev(0, 1'b1);
      pin(!1'(m >> 1), 1'b1);
      rdchk(12'hA00, 8'h01);
      repeat (4) @(posedge clk);
    end
    // Reset in mid-run returns the pin and storage to defaults.
    ev(0, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pin(1'b0, 1'b1);
    rdchk(12'h004, 8'h00);
    rdchk(12'hA00, 8'h00);
    rdchk(12'h008, 8'h00);
    tally_and_finish();
  end
endmodule // framer_interrupt_and_status_map_bench

// >>> frm_chan_regs.sv
/*
 * One framer's eight sticky status bytes and eight enable bytes.
 * Assumes events and clears come from logic on the same clock.
 */
`timescale 1ns/1ps
module frm_chan_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Condition sources and clears.
  input wire logic [63:0] event_in,
  input wire logic [63:0] clr,
  // Enable write port.
  input wire logic en_we,
  input wire logic [2:0] en_sel,
  input wire logic [7:0] en_wdata,
  // State.
  output logic [63:0] status,
  output logic [63:0] enable,
  output logic pending
);

  // Set wins over clear, so an event in the clearing cycle survives.
  always_ff @(posedge clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | event_in;
    end
  end

  // Enable bytes written one at a time.
  always_ff @(posedge clk) begin
    if (rst) begin
      enable <= '0;
    end else if (en_we) begin
      enable[{en_sel, 3'b000} +: 8] <= en_wdata;
    end
  end

  // Each status byte is gated by the enable byte of the same number.
  assign pending = |(status & enable);

endmodule // frm_chan_regs

// >>> frm_defines.svh
/*
 * Offsets, field positions and reset values of the framer interrupt and
 * status map. Assumes word-indexed registers: byte address = 4 * index.
 */
`ifndef FRM_DEFINES_SVH
`define FRM_DEFINES_SVH

// ****************************************************************
// Global register indices.
// ****************************************************************
`define FRM_IDX_FBLK_STAT 12'h000
`define FRM_IDX_FBLK_EN 12'h001
`define FRM_IDX_LBLK_STAT 12'h002
`define FRM_IDX_LBLK_EN 12'h003
`define FRM_IDX_GCA 12'h004
`define FRM_IDX_ID_A 12'h005
`define FRM_IDX_ID_B 12'h006
`define FRM_IDX_ID_C 12'h007
`define FRM_IDX_GCB 12'h008
`define FRM_IDX_PLL 12'h009
`define FRM_IDX_LINK_STAT 12'hA00
`define FRM_IDX_LINK_EN 12'hA02

// ****************************************************************
// Per-framer layout: high digit selects framer, low byte the register.
// ****************************************************************
`define FRM_CH_BASE_DIG 4'h2
`define FRM_OFF_SR_HI 8'h07
`define FRM_OFF_MON_LO 8'h08
`define FRM_OFF_MON_HI 8'h5F
`define FRM_OFF_EN_LO 8'h60
`define FRM_OFF_EN_HI 8'h67
`define FRM_MON_BYTES 88

// ****************************************************************
// Fields and reset values.
// ****************************************************************
`define FRM_GCA_OPEN_BIT 4
`define FRM_GCA_LOW_BIT 6
`define FRM_RST_BYTE 8'h00

`endif

// >>> frm_irq_pin.sv
/*
 * Interrupt pin driver with programmable level and idle state.
 * Assumes the board resolves the wire from irq_out and irq_oe.
 */
`timescale 1ns/1ps
module frm_irq_pin (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Request and mode.
  input wire logic req,
  input wire logic open_drain,
  input wire logic active_low,
  // Pin.
  output logic irq_out,
  output logic irq_oe
);

  // Open mode releases the pin when idle so several devices can share it.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_out <= 1'b0;
      irq_oe <= 1'b1;
    end else begin
      irq_oe <= req | ~open_drain;
      irq_out <= req ? ~active_low : active_low;
    end
  end

endmodule // frm_irq_pin

// >>> frm_irq_top.sv
/*
 * Interrupt gathering and register map of the octal framer, APB slave.
 * Assumes condition and monitor inputs come from logic on clk.
 */
`timescale 1ns/1ps
`include "frm_defines.svh"
module frm_irq_top #(
  parameter int NUM_CHAN = 8,
  // Identity bytes; the values are arbitrary.
  parameter logic [7:0] ID_A = 8'h5A,
  parameter logic [7:0] ID_B = 8'hA5,
  parameter logic [7:0] ID_C = 8'h01
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Framer condition pulses and monitor bytes.
  input wire logic [NUM_CHAN*64-1:0] chan_event,
  input wire logic [NUM_CHAN*`FRM_MON_BYTES*8-1:0] chan_monitor,
  // Data link condition pulses.
  input wire logic [7:0] link_event,
  // Interrupt pin.
  output logic irq_out,
  output logic irq_oe
);

  // ****************************************************************
  // Elaboration check.
  // ****************************************************************
  if (NUM_CHAN < 1 || NUM_CHAN > 8) begin : g_bad_chan
    $error("NUM_CHAN must be 1 to 8");
  end

  localparam logic [3:0] CH_LAST = 4'(`FRM_CH_BASE_DIG + NUM_CHAN - 1);

  // ****************************************************************
  // Registers and decode signals.
  // ****************************************************************
  frm_pkg::frm_apb_state_t st;
  logic [7:0] fblk_stat;
  logic [7:0] fblk_en;
  logic [7:0] lblk_stat;
  logic [7:0] lblk_en;
  logic [7:0] gca;
  logic [7:0] gcb;
  logic [7:0] pll_ctl;
  logic [7:0] link_status;
  logic [7:0] link_irq_enable;
  logic [7:0] clr_mask;
  logic [11:0] idx;
  logic [3:0] digit;
  logic [7:0] off;
  logic [2:0] chan;
  logic is_chan;
  logic [9:0] mon_sel;
  logic [7:0] rd_val;
  logic hit;
  logic sr_hit;
  logic en_hit;
  logic setup;
  logic access_done;
  logic wr_now;
  logic [7:0] clr_byte;
  logic [7:0] link_clr;
  logic [7:0] chan_pend;
  logic [NUM_CHAN*64-1:0] chan_status;
  logic [NUM_CHAN*64-1:0] chan_enable;
  logic irq_req;

  assign idx = paddr[13:2];
  assign digit = idx[11:8];
  assign off = idx[7:0];
  assign chan = 3'(digit - `FRM_CH_BASE_DIG);
  assign is_chan = digit >= `FRM_CH_BASE_DIG && digit <= CH_LAST;
  assign mon_sel = 10'(chan) * 10'(`FRM_MON_BYTES) +
                   10'(off - `FRM_OFF_MON_LO);
  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_now = access_done & pwrite & pstrb[0];
  // A read clears only what it returned; a write clears its one bits.
  assign clr_byte = pwrite ? pwdata[7:0] : clr_mask;

  // ****************************************************************
  // Read decode.
  // ****************************************************************
  // Global map first, then the per-framer windows.
  always_comb begin
    rd_val = 8'h00;
    hit = 1'b0;
    sr_hit = 1'b0;
    en_hit = 1'b0;
    case (idx)
      `FRM_IDX_FBLK_STAT: rd_val = fblk_stat;
      `FRM_IDX_FBLK_EN: rd_val = fblk_en;
      `FRM_IDX_LBLK_STAT: rd_val = lblk_stat;
      `FRM_IDX_LBLK_EN: rd_val = lblk_en;
      `FRM_IDX_GCA: rd_val = gca;
      `FRM_IDX_ID_A: rd_val = ID_A;
      `FRM_IDX_ID_B: rd_val = ID_B;
      `FRM_IDX_ID_C: rd_val = ID_C;
      `FRM_IDX_GCB: rd_val = gcb;
      `FRM_IDX_PLL: rd_val = pll_ctl;
      `FRM_IDX_LINK_STAT: rd_val = link_status;
      `FRM_IDX_LINK_EN: rd_val = link_irq_enable;
      default: rd_val = 8'h00;
    endcase
    if (idx <= `FRM_IDX_PLL || idx == `FRM_IDX_LINK_STAT ||
        idx == `FRM_IDX_LINK_EN) begin
      hit = 1'b1;
    end
    if (is_chan) begin
      if (off <= `FRM_OFF_SR_HI) begin
        hit = 1'b1;
        sr_hit = 1'b1;
        rd_val = chan_status[{chan, off[2:0], 3'b000} +: 8];
      end else if (off <= `FRM_OFF_MON_HI) begin
        // Counters, slot zero, spare bits, stack and signaling bytes.
        hit = 1'b1;
        rd_val = chan_monitor[{mon_sel, 3'b000} +: 8];
      end else if (off <= `FRM_OFF_EN_HI) begin
        hit = 1'b1;
        en_hit = 1'b1;
        rd_val = chan_enable[{chan, off[2:0], 3'b000} +: 8];
      end
    end
  end

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  // One wait-free access phase: data is latched at setup so that
  // prdata and pready come straight from flip-flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= frm_pkg::FRM_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      clr_mask <= 8'h00;
    end else begin
      unique case (st)
        frm_pkg::FRM_IDLE: begin
          if (setup) begin
            st <= frm_pkg::FRM_ACCESS;
            pready <= 1'b1;
            pslverr <= ~hit;
            prdata <= {24'h000000, rd_val};
            clr_mask <= rd_val;
          end
        end
        frm_pkg::FRM_ACCESS: begin
          if (access_done) begin
            st <= frm_pkg::FRM_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Global and link registers.
  // ****************************************************************
  // Writable configuration; read-only and unmapped writes are dropped.
  always_ff @(posedge clk) begin
    if (rst) begin
      fblk_en <= `FRM_RST_BYTE;
      lblk_en <= `FRM_RST_BYTE;
      gca <= `FRM_RST_BYTE;
      gcb <= `FRM_RST_BYTE;
      pll_ctl <= `FRM_RST_BYTE;
      link_irq_enable <= `FRM_RST_BYTE;
    end else if (wr_now) begin
      if (idx == `FRM_IDX_FBLK_EN) fblk_en <= pwdata[7:0];
      if (idx == `FRM_IDX_LBLK_EN) lblk_en <= pwdata[7:0];
      if (idx == `FRM_IDX_GCA) gca <= pwdata[7:0];
      if (idx == `FRM_IDX_GCB) gcb <= pwdata[7:0];
      if (idx == `FRM_IDX_PLL) pll_ctl <= pwdata[7:0];
      if (idx == `FRM_IDX_LINK_EN) link_irq_enable <= pwdata[7:0];
    end
  end

  assign link_clr = (access_done && idx == `FRM_IDX_LINK_STAT &&
                     (pstrb[0] || !pwrite)) ? clr_byte : 8'h00;

  // Link conditions are sticky; set wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      link_status <= 8'h00;
    end else begin
      link_status <= (link_status & ~link_clr) | link_event;
    end
  end

  // Block summaries: one bit per framer, bit zero for the link.
  always_ff @(posedge clk) begin
    if (rst) begin
      fblk_stat <= 8'h00;
      lblk_stat <= 8'h00;
    end else begin
      fblk_stat <= chan_pend;
      lblk_stat <= {7'h00, |(link_status & link_irq_enable)};
    end
  end

  // ****************************************************************
  // Framer register banks.
  // ****************************************************************
  for (genvar g = 0; g < 8; g++) begin : g_chan
    if (g < NUM_CHAN) begin : g_on
      logic sel;
      logic [63:0] clr;
      assign sel = is_chan && chan == 3'(g);
      assign clr = (access_done && sr_hit && sel &&
                    (pstrb[0] || !pwrite)) ?
                   (64'(clr_byte) << {off[2:0], 3'b000}) : 64'h0;
      frm_chan_regs u_regs (
        .clk(clk),
        .rst(rst),
        .event_in(chan_event[g*64 +: 64]),
        .clr(clr),
        .en_we(wr_now && en_hit && sel),
        .en_sel(off[2:0]),
        .en_wdata(pwdata[7:0]),
        .status(chan_status[g*64 +: 64]),
        .enable(chan_enable[g*64 +: 64]),
        .pending(chan_pend[g])
      );
    end else begin : g_off
      assign chan_pend[g] = 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt output.
  // ****************************************************************
  // Held while anything enabled is pending, in any enabled block.
  assign irq_req = |(fblk_stat & fblk_en) | |(lblk_stat & lblk_en);

  frm_irq_pin u_pin (
    .clk(clk),
    .rst(rst),
    .req(irq_req),
    .open_drain(gca[`FRM_GCA_OPEN_BIT]),
    .active_low(gca[`FRM_GCA_LOW_BIT]),
    .irq_out(irq_out),
    .irq_oe(irq_oe)
  );

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  logic asserted;
  assign asserted = irq_oe && (irq_out == ~gca[`FRM_GCA_LOW_BIT]);

  a_link_raises: assert property (@(posedge clk) disable iff (rst)
    (link_event & link_irq_enable) != 0 && lblk_en[0] && !wr_now
    ##1 !wr_now ##1 !wr_now |=> asserted)
    else $error("link condition did not raise interrupt");

  a_block_gate: assert property (@(posedge clk) disable iff (rst)
    (fblk_en == 8'h00 && lblk_en == 8'h00)[*2] |-> !irq_req ##1 !asserted)
    else $error("interrupt raised with all blocks disabled");

  a_read_clears: assert property (@(posedge clk) disable iff (rst)
    access_done && !pwrite && idx == `FRM_IDX_LINK_STAT |=>
    (link_status & $past(clr_mask) & ~$past(link_event)) == 8'h00)
    else $error("link status not cleared by read");

  a_chan_pair: assert property (@(posedge clk) disable iff (rst)
    fblk_stat[0] == $past(|(chan_status[63:0] & chan_enable[63:0])))
    else $error("framer summary does not follow its enables");

  a_reset_idle: assert property (@(posedge clk)
    rst |=> irq_oe && !irq_out)
    else $error("pin not low driven after reset");

  a_pin_mode: assert property (@(posedge clk) disable iff (rst)
    !irq_req |=>
    irq_oe == !$past(gca[`FRM_GCA_OPEN_BIT]) &&
    (!irq_oe || irq_out == $past(gca[`FRM_GCA_LOW_BIT])))
    else $error("idle pin drive wrong for mode");

  a_chan_decode: assert property (@(posedge clk) disable iff (rst)
    setup && idx == 12'h260 && st == frm_pkg::FRM_IDLE |=>
    prdata[7:0] == chan_enable[7:0] && !pslverr)
    else $error("framer one enable not at digit two");

  a_global_map: assert property (@(posedge clk) disable iff (rst)
    setup && st == frm_pkg::FRM_IDLE && idx == `FRM_IDX_GCA |=>
    prdata == {24'h000000, $past(gca)} && pready)
    else $error("global control read wrong");

  a_unmapped_err: assert property (@(posedge clk) disable iff (rst)
    setup && st == frm_pkg::FRM_IDLE && idx == 12'h00A |=> pslverr)
    else $error("unmapped index not refused");

  a_pend_holds: assert property (@(posedge clk) disable iff (rst)
    (lblk_stat[0] && lblk_en[0] && !wr_now)[*2] |=> asserted)
    else $error("interrupt dropped while condition pending");

  c_link_clear: cover property (@(posedge clk) disable iff (rst)
    access_done && !pwrite && idx == `FRM_IDX_LINK_STAT &&
    clr_mask != 8'h00);

  c_irq_rise: cover property (@(posedge clk) disable iff (rst)
    !irq_req ##1 irq_req);

  c_open_low: cover property (@(posedge clk) disable iff (rst)
    gca[`FRM_GCA_OPEN_BIT] && gca[`FRM_GCA_LOW_BIT] && irq_req);

endmodule // frm_irq_top

// >>> frm_pkg.sv
/*
 * Types shared by the framer interrupt and status map.
 * Assumes nothing of its surroundings.
 */
package frm_pkg;

  // Bus slave phase, one-hot.
  typedef enum logic [1:0] {
    FRM_IDLE = 2'b01,
    FRM_ACCESS = 2'b10
  } frm_apb_state_t;

endpackage
